// ---- common/cfg_regs_pkg.sv ----
package cfg_regs_pkg;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [23:0] BUF_CFG_BASE = 24'h01_0000;
  localparam logic [23:0] WATERMARK_OFS = 24'h00_0000;
  localparam logic [23:0] STORE_CTRL_OFS = 24'h00_0004;
  localparam logic [23:0] WATERMARK_ADDR = BUF_CFG_BASE + WATERMARK_OFS;
  localparam logic [23:0] STORE_CTRL_ADDR = BUF_CFG_BASE + STORE_CTRL_OFS;
  localparam logic [23:0] MAINT_INFO_ADDR = 24'h01_0100;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int WM_W = 6;
  localparam int THR2_LSB = 16;
  localparam int THR1_LSB = 8;
  localparam int THR0_LSB = 0;
  localparam int RX_FC_ONLY_BIT = 31;
  localparam int UNIFIED_CLK_BIT = 30;
  localparam int TX_FC_BIT = 29;
  localparam int TX_REORDER_BIT = 28;
  localparam int TX_SIZE_LSB = 16;
  localparam int TX_SIZE_W = 11;
  localparam int FORCE_RX_FC_BIT = 15;
  localparam int RX_SIZE_LSB = 0;
  localparam int RX_SIZE_W = 8;
  localparam int TID_LSB = 24;
  localparam int PRIO_LSB = 17;
  localparam int CRF_BIT = 16;
  localparam int DEST_LSB = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [5:0] PRIO0_THR_RST = 6'h03;
  localparam logic [5:0] PRIO1_THR_RST = 6'h02;
  localparam logic [5:0] PRIO2_THR_RST = 6'h01;
  localparam logic FORCE_RX_FC_RST = 1'b0;
  localparam logic [7:0] TID_RST = 8'h00;
  localparam logic [1:0] PRIO_RST = 2'b01;
  localparam logic CRF_RST = 1'b0;
  localparam logic [15:0] DEST_RST = 16'h0000;
  localparam logic [10:0] TX_SIZE_DEF = 11'h020;
  localparam logic [7:0] RX_SIZE_DEF = 8'h20;
  localparam logic [3:0] SEND_OK_RST = 4'h0;
  localparam logic [3:0] SEND_ALL = 4'hF;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [7:0] tid;
    logic [1:0] prio;
    logic crf;
    logic [15:0] dest_id;
  } maint_hdr_t;

  typedef struct packed {
    logic [5:0] prio2;
    logic [5:0] prio1;
    logic [5:0] prio0;
  } thresholds_t;

  function automatic logic [31:0] wm_pack(input thresholds_t t);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[THR2_LSB +: WM_W] = t.prio2;
    w[THR1_LSB +: WM_W] = t.prio1;
    w[THR0_LSB +: WM_W] = t.prio0;
    return w;
  endfunction

  function automatic thresholds_t wm_unpack(input logic [31:0] w);
    thresholds_t t;
    t.prio2 = w[THR2_LSB +: WM_W];
    t.prio1 = w[THR1_LSB +: WM_W];
    t.prio0 = w[THR0_LSB +: WM_W];
    return t;
  endfunction

  function automatic logic [31:0] mi_pack(input maint_hdr_t h);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TID_LSB +: 8] = h.tid;
    w[PRIO_LSB +: 2] = h.prio;
    w[CRF_BIT] = h.crf;
    w[DEST_LSB +: 16] = h.dest_id;
    return w;
  endfunction

endpackage

// ---- dv/buffer_maint_config_regs_test.sv ----
`timescale 1ns/100ps
module buffer_maint_config_regs_test;
  import cfg_regs_pkg::*;
  logic core_clk, rst, cfg_valid, cfg_ack, cfg_err, tx_fc_active, maint_req_sent;
  logic link_tx_fc_ok, send_req, fc_ok_cmd, er;
  logic [5:0] partner_free_space, space_cmd;
  logic [31:0] cfg_rdata, rd;
  logic [3:0] prio_send_ok, ok_exp;
  cfg_req_t cfg_req;
  thresholds_t thresholds;
  maint_hdr_t maint_hdr, sent_hdr;
  int err_total, checks_done;

  buffer_maint_config_regs #(.RX_FC_ONLY(1'b0), .UNIFIED_CLK(1'b0), .TX_REORDER(1'b0), .CRF_SUPPORT(1'b1),
    .MAINT_PORT_PRESENT(1'b1), .TX_SIZE(TX_SIZE_DEF), .RX_SIZE(RX_SIZE_DEF)) u_dut (
    .core_clk(core_clk), .rst(rst), .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .link_tx_fc_ok(link_tx_fc_ok),
    .partner_free_space(partner_free_space), .prio_send_ok(prio_send_ok), .tx_fc_active(tx_fc_active),
    .thresholds(thresholds), .maint_req_sent(maint_req_sent), .maint_hdr(maint_hdr));

  link_partner_model u_partner (
    .core_clk(core_clk), .rst(rst), .fc_ok_cmd(fc_ok_cmd), .space_cmd(space_cmd), .send_req(send_req),
    .maint_hdr(maint_hdr), .link_tx_fc_ok(link_tx_fc_ok), .partner_free_space(partner_free_space),
    .maint_req_sent(maint_req_sent), .sent_hdr(sent_hdr));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // one access; ack is a registered one-cycle answer, no backpressure
  task automatic access(input logic we, input logic [23:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    cfg_valid = 1'b1;
    cfg_req = '{we: we, addr: addr, wdata: wd};
    tick(1);
    cfg_valid = 1'b0;
    while (cfg_ack !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      err_total++;
      finish_test();
    end
    rd = cfg_rdata;
    er = cfg_err;
    tick(1);
  endtask

  task automatic rd_chk(input logic [23:0] addr, input logic [31:0] exp);
    access(1'b0, addr, 32'h0000_0000);
    check(rd, exp);
    check(32'(er), 32'h0000_0000);
  endtask

  function automatic logic [31:0] ctrl_word(input logic txfc, input logic frc);
    return {1'b0, 1'b0, txfc, 1'b0, 1'b0, TX_SIZE_DEF, frc, 7'h00, RX_SIZE_DEF};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    cfg_valid = 1'b0;
    cfg_req = '0;
    send_req = 1'b0;
    fc_ok_cmd = 1'b1;
    space_cmd = 6'h00;
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    tick(4);
    rd_chk(WATERMARK_ADDR, 32'h0001_0203);
    rd_chk(STORE_CTRL_ADDR, ctrl_word(1'b1, 1'b0));
    rd_chk(MAINT_INFO_ADDR, 32'h0002_0000);
    $display("test reset_values done");
    // ordered thresholds 5/4/2, reserved bits set in the write
    access(1'b1, WATERMARK_ADDR, 32'hFFC2_C4C5);
    check(rd, 32'h0000_0000);
    check(32'(thresholds), 32'({6'h02, 6'h04, 6'h05}));
    rd_chk(WATERMARK_ADDR, 32'h0002_0405);
    for (int f = 0; f < 7; f++) begin
      space_cmd = 6'(f);
      tick(3);
      ok_exp = {f != 0, f >= 2, f >= 4, f >= 5};
      check(32'(prio_send_ok), 32'(ok_exp));
    end
    $display("test threshold_gate done");
    space_cmd = 6'h00;
    access(1'b1, STORE_CTRL_ADDR, 32'hFFFF_FFFF);
    tick(3);
    check(32'(tx_fc_active), 32'h0000_0000);
    check(32'(prio_send_ok), 32'h0000_000F);
    rd_chk(STORE_CTRL_ADDR, ctrl_word(1'b0, 1'b1));
    access(1'b1, STORE_CTRL_ADDR, 32'h0000_0000);
    fc_ok_cmd = 1'b0;
    tick(4);
    rd_chk(STORE_CTRL_ADDR, ctrl_word(1'b0, 1'b0));
    check(32'(prio_send_ok), 32'h0000_000F);
    fc_ok_cmd = 1'b1;
    tick(4);
    rd_chk(STORE_CTRL_ADDR, ctrl_word(1'b1, 1'b0));
    $display("test flow_control done");
    access(1'b1, MAINT_INFO_ADDR, 32'hABFF_1234);
    check(32'(maint_hdr), 32'({8'hAB, 2'b11, 1'b1, 16'h1234}));
    rd_chk(MAINT_INFO_ADDR, 32'hAB07_1234);
    // two requests back to back
    send_req = 1'b1;
    tick(2);
    send_req = 1'b0;
    tick(3);
    check(32'(sent_hdr.tid), 32'h0000_00AC);
    check(32'(maint_hdr.tid), 32'h0000_00AD);
    access(1'b1, MAINT_INFO_ADDR, 32'hFF00_0000);
    send_req = 1'b1;
    tick(1);
    send_req = 1'b0;
    tick(3);
    check(32'(sent_hdr), 32'({8'hFF, 2'b00, 1'b0, 16'h0000}));
    check(32'(maint_hdr.tid), 32'h0000_0000);
    $display("test maint_info done");
    access(1'b1, 24'h01_0008, 32'hFFFF_FFFF);
    check(32'(er), 32'h0000_0001);
    access(1'b0, 24'h01_0008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    access(1'b0, 24'h00_0000, 32'h0000_0000);
    check(32'(er), 32'h0000_0001);
    rd_chk(WATERMARK_ADDR, 32'h0002_0405);
    $display("test unmapped done");
    finish_test();
  end
endmodule

// ---- dv/link_partner_model.sv ----
`timescale 1ns/100ps
module link_partner_model (
  input logic core_clk,
  input logic rst,
  input logic fc_ok_cmd,
  input logic [5:0] space_cmd,
  input logic send_req,
  input cfg_regs_pkg::maint_hdr_t maint_hdr,
  output logic link_tx_fc_ok,
  output logic [5:0] partner_free_space,
  output logic maint_req_sent,
  output cfg_regs_pkg::maint_hdr_t sent_hdr
);
  import cfg_regs_pkg::*;

  // ----------------------------------------
  // link side levels and request launch
  // ----------------------------------------
  // header taken at send
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_tx_fc_ok <= 1'b0;
      partner_free_space <= 6'h00;
      maint_req_sent <= 1'b0;
      sent_hdr <= '0;
    end else begin
      link_tx_fc_ok <= fc_ok_cmd;
      partner_free_space <= space_cmd;
      maint_req_sent <= send_req;
      // header is latched on the edge the block sees the pulse, before its increment lands
      if (maint_req_sent) begin
        sent_hdr <= maint_hdr;
      end
    end
  end
endmodule

// ---- src/buffer_maint_config_regs.sv ----
`timescale 1ns/100ps
// Operation
// [RULE1] software keeps 64 > prio0 > prio1 > prio2 > 0 thresholds always
// [RULE2] bits 21:16 hold least partner space for priority 2 sends
// [RULE3] bits 13:8 hold least partner space for priority 1 sends
// [RULE4] bits 5:0 hold least partner space for priority 0 sends
// [RULE5] thresholds gate priorities only in transmitter-controlled flow control
// [RULE6] software should use thresholds 3, 2, 1 on small buffers
// [RULE7] software should stop traffic before rewriting thresholds
// [RULE8] control bit 31 reads receiver-flow-control-only build
// [RULE9] control bit 30 reads single-clock build; both layers share one clock
// [RULE10] control bit 29 reads one while transmitter flow control active
// [RULE11] control bit 28 reads one when request reordering built in
// [RULE12] control bits 26:16 read transmit buffer packet capacity
// [RULE13] bit 15 forces receiver flow control; ignored on receiver-only builds
// [RULE14] control bits 7:0 read receive buffer packet capacity
// [RULE15] request tid goes into next request, then increments
// [RULE16] request priority bits 18:17, reset to 01
// [RULE17] request crf bit 16, read-only without crf support
// [RULE18] request destination id bits 15:0
// [RULE19] request info register exists only with maintenance port present
// [RULE20] buffer registers sit at fixed base in implementation space
// [RULE21] user logic rewrites request info before each remote request
// [RULE22] reserved bits read zero; read-only and reserved writes ignored
module buffer_maint_config_regs #(
  parameter bit RX_FC_ONLY = 1'b0,
  parameter bit UNIFIED_CLK = 1'b0,
  parameter bit TX_REORDER = 1'b0,
  parameter bit CRF_SUPPORT = 1'b1,
  parameter bit MAINT_PORT_PRESENT = 1'b1,
  parameter logic [10:0] TX_SIZE = cfg_regs_pkg::TX_SIZE_DEF,
  parameter logic [7:0] RX_SIZE = cfg_regs_pkg::RX_SIZE_DEF
) (
  input logic core_clk,
  input logic rst,
  input logic cfg_valid,
  input cfg_regs_pkg::cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic cfg_err,
  output logic [31:0] cfg_rdata,
  input logic link_tx_fc_ok,
  input logic [5:0] partner_free_space,
  output logic [3:0] prio_send_ok,
  output logic tx_fc_active,
  output cfg_regs_pkg::thresholds_t thresholds,
  input logic maint_req_sent,
  output cfg_regs_pkg::maint_hdr_t maint_hdr
);
  import cfg_regs_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  thresholds_t wm_reg;
  thresholds_t wm_next;
  logic force_rx_fc_reg;
  logic force_rx_fc_next;
  logic tx_fc_reg;
  logic tx_fc_next;
  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic mi_wr;
  logic [31:0] ctrl_word;
  maint_hdr_t hdr;

  // ----------------------------------------
  // buffer control readback
  // ----------------------------------------
  always_comb begin
    ctrl_word = 32'h0000_0000;
    // [RULE8] receiver-only build flag
    ctrl_word[RX_FC_ONLY_BIT] = RX_FC_ONLY;
    // [RULE9] single-clock build flag
    ctrl_word[UNIFIED_CLK_BIT] = UNIFIED_CLK;
    // [RULE10] live flow control mode
    ctrl_word[TX_FC_BIT] = tx_fc_reg;
    // [RULE11] reorder build flag
    ctrl_word[TX_REORDER_BIT] = TX_REORDER;
    // [RULE12] transmit capacity
    ctrl_word[TX_SIZE_LSB +: TX_SIZE_W] = TX_SIZE;
    ctrl_word[FORCE_RX_FC_BIT] = force_rx_fc_reg;
    // [RULE14] receive capacity
    ctrl_word[RX_SIZE_LSB +: RX_SIZE_W] = RX_SIZE;
  end

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  always_comb begin
    wm_next = wm_reg;
    force_rx_fc_next = force_rx_fc_reg;
    ack_next = cfg_valid;
    err_next = 1'b0;
    rdata_next = 32'h0000_0000;
    mi_wr = 1'b0;
    if (cfg_valid) begin
      // [RULE20] fixed base decode
      if (cfg_req.addr == WATERMARK_ADDR) begin
        if (cfg_req.we) begin
          // [RULE2] [RULE3] [RULE4] thresholds stored
          wm_next = wm_unpack(cfg_req.wdata);
        end else begin
          // [RULE22] reserved bits zero
          rdata_next = wm_pack(wm_reg);
        end
      end else if (cfg_req.addr == STORE_CTRL_ADDR) begin
        if (cfg_req.we) begin
          // [RULE13] force ignored on receiver-only
          if (!RX_FC_ONLY) begin
            force_rx_fc_next = cfg_req.wdata[FORCE_RX_FC_BIT];
          end
        end else begin
          rdata_next = ctrl_word;
        end
      end else if (MAINT_PORT_PRESENT && cfg_req.addr == MAINT_INFO_ADDR) begin
        // [RULE19] present only with maintenance port
        if (cfg_req.we) begin
          mi_wr = 1'b1;
        end else begin
          rdata_next = mi_pack(hdr);
        end
      end else begin
        err_next = 1'b1;
      end
    end
    // [RULE13] forced mode overrides partner capability
    // [RULE10] mode tracks build, force bit and link
    tx_fc_next = !RX_FC_ONLY && !force_rx_fc_reg && link_tx_fc_ok;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wm_reg.prio0 <= PRIO0_THR_RST;
      wm_reg.prio1 <= PRIO1_THR_RST;
      wm_reg.prio2 <= PRIO2_THR_RST;
      force_rx_fc_reg <= FORCE_RX_FC_RST;
      tx_fc_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wm_reg <= wm_next;
      force_rx_fc_reg <= force_rx_fc_next;
      tx_fc_reg <= tx_fc_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  // [RULE5] thresholds applied by the gate
  prio_gate u_gate (
    .core_clk(core_clk),
    .rst(rst),
    .thr(wm_reg),
    .free_space(partner_free_space),
    .tx_fc_active(tx_fc_reg),
    .send_ok(prio_send_ok)
  );

  maint_info_reg #(
    .CRF_SUPPORT(CRF_SUPPORT)
  ) u_info (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(mi_wr),
    .wdata(cfg_req.wdata),
    .req_sent(maint_req_sent),
    .hdr(hdr)
  );

  assign cfg_ack = ack_reg;
  assign cfg_err = err_reg;
  assign cfg_rdata = rdata_reg;
  assign tx_fc_active = tx_fc_reg;
  assign thresholds = wm_reg;
  assign maint_hdr = hdr;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_wm2_store;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && cfg_req.we && cfg_req.addr == WATERMARK_ADDR)
        |=> wm_reg.prio2 == $past(cfg_req.wdata[21:16]);
  endproperty
  a_wm2_store: assert property (p_wm2_store) else $error("priority 2 threshold not stored"); // [RULE2]

  property p_wm1_store;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && cfg_req.we && cfg_req.addr == WATERMARK_ADDR)
        |=> wm_reg.prio1 == $past(cfg_req.wdata[13:8]);
  endproperty
  a_wm1_store: assert property (p_wm1_store) else $error("priority 1 threshold not stored"); // [RULE3]

  property p_wm0_readback;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == WATERMARK_ADDR)
        |=> cfg_ack && cfg_rdata[5:0] == $past(wm_reg.prio0) && cfg_rdata[31:22] == 10'h000;
  endproperty
  a_wm0_readback: assert property (p_wm0_readback) else $error("threshold readback wrong"); // [RULE4]

  property p_ctrl_build_bits;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == STORE_CTRL_ADDR)
        |=> cfg_rdata[31] == RX_FC_ONLY && cfg_rdata[30] == UNIFIED_CLK && cfg_rdata[28] == TX_REORDER;
  endproperty
  a_ctrl_build_bits: assert property (p_ctrl_build_bits) else $error("build flags misreported"); // [RULE8]

  property p_ctrl_mode_bit;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == STORE_CTRL_ADDR)
        |=> cfg_rdata[29] == $past(tx_fc_reg);
  endproperty
  a_ctrl_mode_bit: assert property (p_ctrl_mode_bit) else $error("flow control mode misreported"); // [RULE10]

  property p_ctrl_sizes;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == STORE_CTRL_ADDR)
        |=> cfg_rdata[26:16] == TX_SIZE && cfg_rdata[7:0] == RX_SIZE && cfg_rdata[14:8] == 7'h00;
  endproperty
  a_ctrl_sizes: assert property (p_ctrl_sizes) else $error("buffer sizes misreported"); // [RULE12]

  property p_force_write;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && cfg_req.we && cfg_req.addr == STORE_CTRL_ADDR)
        |=> force_rx_fc_reg == (!RX_FC_ONLY && $past(cfg_req.wdata[15]));
  endproperty
  a_force_write: assert property (p_force_write) else $error("force bit write handled wrongly"); // [RULE13]

  property p_forced_mode;
    @(posedge core_clk) disable iff (rst) force_rx_fc_reg |=> !tx_fc_reg;
  endproperty
  a_forced_mode: assert property (p_forced_mode) else $error("tx flow control while forced off"); // [RULE10]

  property p_info_absent;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !MAINT_PORT_PRESENT && cfg_req.addr == MAINT_INFO_ADDR) |=> cfg_err && cfg_rdata == 32'h0000_0000;
  endproperty
  a_info_absent: assert property (p_info_absent) else $error("request info reachable without port"); // [RULE19]

  property p_info_readback;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && MAINT_PORT_PRESENT && cfg_req.addr == MAINT_INFO_ADDR)
        |=> cfg_rdata[15:0] == $past(hdr.dest_id) && cfg_rdata[23:19] == 5'h00;
  endproperty
  a_info_readback: assert property (p_info_readback) else $error("request info readback wrong"); // [RULE18]

  property p_ack_timing;
    @(posedge core_clk) disable iff (rst) cfg_valid |=> cfg_ack ##1 (cfg_ack == $past(cfg_valid));
  endproperty
  a_ack_timing: assert property (p_ack_timing) else $error("access not answered in one cycle"); // [RULE20]

  property p_wm_fields;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == WATERMARK_ADDR)
        |=> cfg_rdata[21:16] == $past(wm_reg.prio2) && cfg_rdata[13:8] == $past(wm_reg.prio1)
          && cfg_rdata[15:14] == 2'b00 && cfg_rdata[7:6] == 2'b00;
  endproperty
  a_wm_fields: assert property (p_wm_fields) else $error("threshold fields misplaced"); // [RULE22]

  // thresholds only move on a watermark write
  property p_wm_hold;
    @(posedge core_clk) disable iff (rst)
      !(cfg_valid && cfg_req.we && cfg_req.addr == WATERMARK_ADDR) |=> wm_reg == $past(wm_reg);
  endproperty
  a_wm_hold: assert property (p_wm_hold) else $error("thresholds changed without a write"); // [RULE2]

  property p_force_readback;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && cfg_req.addr == STORE_CTRL_ADDR)
        |=> cfg_rdata[15] == $past(force_rx_fc_reg) && cfg_rdata[27] == 1'b0;
  endproperty
  a_force_readback: assert property (p_force_readback) else $error("force bit misreported"); // [RULE13]

  property p_link_off_mode;
    @(posedge core_clk) disable iff (rst) !link_tx_fc_ok |=> !tx_fc_reg;
  endproperty
  a_link_off_mode: assert property (p_link_off_mode) else $error("tx flow control without partner"); // [RULE10]

  property p_link_on_mode;
    @(posedge core_clk) disable iff (rst)
      (link_tx_fc_ok && !force_rx_fc_reg && !RX_FC_ONLY) |=> tx_fc_reg;
  endproperty
  a_link_on_mode: assert property (p_link_on_mode) else $error("tx flow control not entered"); // [RULE10]

  property p_info_fields;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && !cfg_req.we && MAINT_PORT_PRESENT && cfg_req.addr == MAINT_INFO_ADDR)
        |=> cfg_rdata[31:24] == $past(hdr.tid) && cfg_rdata[18:17] == $past(hdr.prio)
          && cfg_rdata[16] == $past(hdr.crf);
  endproperty
  a_info_fields: assert property (p_info_fields) else $error("request info fields wrong"); // [RULE16]

  // unmapped access answers with error and zero data
  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      (cfg_valid && cfg_req.addr != WATERMARK_ADDR && cfg_req.addr != STORE_CTRL_ADDR
        && cfg_req.addr != MAINT_INFO_ADDR) |=> cfg_err && cfg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused"); // [RULE22]

  property p_write_zero;
    @(posedge core_clk) disable iff (rst) (cfg_valid && cfg_req.we) |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned read data"); // [RULE22]

  property p_idle_quiet;
    @(posedge core_clk) disable iff (rst) !cfg_valid |=> !cfg_ack && !cfg_err && cfg_rdata == 32'h0000_0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without access"); // [RULE20]

  c_wm_write: cover property (@(posedge core_clk) disable iff (rst)
    cfg_valid && cfg_req.we && cfg_req.addr == WATERMARK_ADDR);
  c_force_rx: cover property (@(posedge core_clk) disable iff (rst) tx_fc_reg ##1 force_rx_fc_reg ##1 !tx_fc_reg);
  c_gate_block: cover property (@(posedge core_clk) disable iff (rst) tx_fc_reg && prio_send_ok[0] == 1'b0);
  c_tid_step: cover property (@(posedge core_clk) disable iff (rst) maint_req_sent ##1 maint_req_sent);
  c_unmapped: cover property (@(posedge core_clk) disable iff (rst) cfg_valid ##1 cfg_err);
endmodule

// ---- src/maint_info_reg.sv ----
`timescale 1ns/100ps
module maint_info_reg #(
  parameter bit CRF_SUPPORT = 1'b1
) (
  input logic core_clk,
  input logic rst,
  input logic wr_en,
  input logic [31:0] wdata,
  input logic req_sent,
  output cfg_regs_pkg::maint_hdr_t hdr
);
  import cfg_regs_pkg::*;

  maint_hdr_t hdr_reg;
  maint_hdr_t hdr_next;

  always_comb begin
    hdr_next = hdr_reg;
    // [RULE15] tid steps per sent request
    if (req_sent) begin
      hdr_next.tid = hdr_reg.tid + 8'h01;
    end
    // a write lands after the increment so software sets the next tid exactly
    if (wr_en) begin
      hdr_next.tid = wdata[TID_LSB +: 8];
      // [RULE16] request priority field
      hdr_next.prio = wdata[PRIO_LSB +: 2];
      // [RULE17] crf writable only with support
      if (CRF_SUPPORT) begin
        hdr_next.crf = wdata[CRF_BIT];
      end
      // [RULE18] destination id
      hdr_next.dest_id = wdata[DEST_LSB +: 16];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hdr_reg.tid <= TID_RST;
      hdr_reg.prio <= PRIO_RST;
      hdr_reg.crf <= CRF_RST;
      hdr_reg.dest_id <= DEST_RST;
    end else begin
      hdr_reg <= hdr_next;
    end
  end

  assign hdr = hdr_reg;

  property p_tid_increment;
    @(posedge core_clk) disable iff (rst)
      (req_sent && !wr_en) |=> hdr.tid == $past(hdr.tid) + 8'h01;
  endproperty
  a_tid_increment: assert property (p_tid_increment) else $error("tid did not step after request"); // [RULE15]

  property p_prio_reset;
    @(posedge core_clk) disable iff (rst) $fell(rst) |-> hdr.prio == PRIO_RST;
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("request priority wrong after reset"); // [RULE16]

  property p_crf_locked;
    @(posedge core_clk) disable iff (rst) !CRF_SUPPORT |-> hdr.crf == CRF_RST;
  endproperty
  a_crf_locked: assert property (p_crf_locked) else $error("crf changed without support"); // [RULE17]
endmodule

// ---- src/prio_gate.sv ----
`timescale 1ns/100ps
module prio_gate (
  input logic core_clk,
  input logic rst,
  input cfg_regs_pkg::thresholds_t thr,
  input logic [5:0] free_space,
  input logic tx_fc_active,
  output logic [3:0] send_ok
);
  import cfg_regs_pkg::*;

  logic [3:0] send_ok_reg;
  logic [3:0] send_ok_next;

  function automatic logic meets(input logic [5:0] space, input logic [5:0] limit);
    return space >= limit;
  endfunction

  always_comb begin
    // [RULE5] gate only in tx flow control
    if (tx_fc_active) begin
      send_ok_next[0] = meets(free_space, thr.prio0);
      send_ok_next[1] = meets(free_space, thr.prio1);
      send_ok_next[2] = meets(free_space, thr.prio2);
      send_ok_next[3] = (free_space != 6'h00);
    end else begin
      send_ok_next = SEND_ALL;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      send_ok_reg <= SEND_OK_RST;
    end else begin
      send_ok_reg <= send_ok_next;
    end
  end

  assign send_ok = send_ok_reg;

  property p_rx_fc_all_open;
    @(posedge core_clk) disable iff (rst) !tx_fc_active |=> send_ok == SEND_ALL;
  endproperty
  a_rx_fc_all_open: assert property (p_rx_fc_all_open) else $error("priority gated outside tx flow control"); // [RULE5]

  property p_prio0_threshold;
    @(posedge core_clk) disable iff (rst)
      (tx_fc_active && free_space < thr.prio0) |=> !send_ok[0];
  endproperty
  a_prio0_threshold: assert property (p_prio0_threshold) else $error("priority 0 sent below its threshold"); // [RULE4]
endmodule
